//--- verilog/arg_ramp.sv
`timescale 1ns/100ps
// Summary of operation
// - enable rise drives start/stop level 100 ms, then ramps to target
// - enable fall sets level to offset at once, output becomes zero
// - level_choice low picks target one, high picks target two
// - level_choice change ramps from present level to the new target
// - ramp_down_cmd rise ramps level steadily, up or down, to the start/stop level
// - stop holds start/stop level 100 ms, then level drops to offset
// - both target levels accepted as signed -10000 to 20000
// - current level never exceeds level_ceiling, itself -10000 to 20000
// - start/stop level is offset plus start_stop_offset, 0 to 20000
// - level moves at programmed rate in steps per second, 1 to 10000
// - gain 0 to 10.00 in hundredths, offset -10000 to 10000
// - scaled out is (level minus offset) over gain, kept 0 to 32767
// - decimal_places setting stored as 0, 1, 2 or 3
// - level is updated once every 100 ms by the rate-limited step
// - after a stop, restarts ignored until ramp_down_cmd and enable low
module arg_ramp #(
  parameter int TICK_LEN = arg_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control inputs, asynchronous to clk
  input wire logic enable,
  input wire logic level_choice,
  input wire logic ramp_down_cmd,
  // register port
  input wire logic [arg_pkg::AW-1:0] reg_addr,
  input wire logic [arg_pkg::DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [arg_pkg::DW-1:0] reg_rdata,
  // results
  output logic signed [arg_pkg::LW-1:0] current_level,
  output logic [arg_pkg::OW-1:0] scaled_analog_out
);
  import arg_pkg::*;

  function automatic logic signed [LW-1:0] clampv(
    input logic signed [LW-1:0] v,
    input logic signed [LW-1:0] lo,
    input logic signed [LW-1:0] hi
  );
    clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // one rate-limited move of cur toward tgt
  function automatic logic signed [LW-1:0] toward(
    input logic signed [LW-1:0] cur,
    input logic signed [LW-1:0] tgt,
    input logic signed [LW-1:0] stp
  );
    if (cur < tgt) begin
      toward = (tgt - cur <= stp) ? tgt : cur + stp;
    end else begin
      toward = (cur - tgt <= stp) ? tgt : cur - stp;
    end
  endfunction

  // two-flop synchronisers, then one more stage for edges
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] prev_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      prev_reg <= 3'h0;
    end else begin
      sync1_reg <= {ramp_down_cmd, level_choice, enable};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  logic en_s;
  logic sel_s;
  logic stop_s;
  logic en_rise;
  logic en_fall;
  logic stop_rise;
  assign en_s = sync2_reg[0];
  assign sel_s = sync2_reg[1];
  assign stop_s = sync2_reg[2];
  assign en_rise = en_s & ~prev_reg[0];
  assign en_fall = ~en_s & prev_reg[0];
  assign stop_rise = stop_s & ~prev_reg[2];

  // configuration registers
  logic signed [LW-1:0] level1_reg, level1_next;
  logic signed [LW-1:0] level2_reg, level2_next;
  logic signed [LW-1:0] ceiling_reg, ceiling_next;
  logic signed [LW-1:0] ss_reg, ss_next;
  logic signed [LW-1:0] rate_reg, rate_next;
  logic signed [LW-1:0] gain_reg, gain_next;
  logic signed [LW-1:0] offset_reg, offset_next;
  logic signed [LW-1:0] dec_reg, dec_next;
  logic signed [LW-1:0] wval;
  assign wval = {{(LW-DW){reg_wdata[DW-1]}}, reg_wdata};

  // writes are clamped into range, never refused
  always_comb begin
    level1_next = level1_reg;
    level2_next = level2_reg;
    ceiling_next = ceiling_reg;
    ss_next = ss_reg;
    rate_next = rate_reg;
    gain_next = gain_reg;
    offset_next = offset_reg;
    dec_next = dec_reg;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_LEVEL1: level1_next = clampv(wval, LEVEL_MIN, LEVEL_MAX);
        ADDR_LEVEL2: level2_next = clampv(wval, LEVEL_MIN, LEVEL_MAX);
        ADDR_CEILING: ceiling_next = clampv(wval, LEVEL_MIN, LEVEL_MAX);
        ADDR_SS_OFF: ss_next = clampv(wval, SS_MIN, SS_MAX);
        ADDR_RATE: rate_next = clampv(wval, RATE_MIN, RATE_MAX);
        ADDR_GAIN: gain_next = clampv(wval, GAIN_MIN, GAIN_MAX);
        ADDR_OFFSET: offset_next = clampv(wval, OFFS_MIN, OFFS_MAX);
        ADDR_DECIMALS: dec_next = clampv(wval, DEC_MIN, DEC_MAX);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      level1_reg <= RST_LEVEL;
      level2_reg <= RST_LEVEL;
      ceiling_reg <= RST_CEILING;
      ss_reg <= RST_SS;
      rate_reg <= RST_RATE;
      gain_reg <= RST_GAIN;
      offset_reg <= RST_OFFSET;
      dec_reg <= RST_DEC;
    end else begin
      level1_reg <= level1_next;
      level2_reg <= level2_next;
      ceiling_reg <= ceiling_next;
      ss_reg <= ss_next;
      rate_reg <= rate_next;
      gain_reg <= gain_next;
      offset_reg <= offset_next;
      dec_reg <= dec_next;
    end
  end

  // derived levels
  logic signed [LW-1:0] ss_level;
  logic signed [LW-1:0] target;
  assign ss_level = offset_reg + ss_reg;
  assign target = sel_s ? level2_reg : level1_reg;

  // sequencer, level, prescaler and step remainder
  arg_state_e state_reg, state_next;
  logic signed [LW-1:0] level_reg, level_next;
  logic [TW-1:0] tick_cnt_reg, tick_cnt_next;
  logic [LW-1:0] rem_reg, rem_next;
  logic tick;
  logic [LW-1:0] tot;
  logic signed [LW-1:0] step;
  logic signed [LW-1:0] lvl;

  // restarting the prescaler on each hold makes holds a full 100 ms
  assign tick = (tick_cnt_reg == TW'(TICK_LEN - 1));
  // fractional steps carried so slow rates still move
  assign tot = rem_reg + rate_reg;
  assign step = LW'(tot / STEPS_PER_TICK_DIV);

  always_comb begin
    state_next = state_reg;
    lvl = level_reg;
    rem_next = rem_reg;
    tick_cnt_next = tick ? '0 : tick_cnt_reg + 1'b1;
    case (state_reg)
      ARG_IDLE: begin
        lvl = offset_reg;
        if (en_rise) begin
          state_next = ARG_START_HOLD;
          lvl = ss_level;
          tick_cnt_next = '0;
        end
      end
      ARG_START_HOLD: begin
        lvl = ss_level;
        if (stop_rise) begin
          state_next = ARG_STOP_RAMP;
        end else if (tick) begin
          state_next = ARG_RAMP;
          rem_next = '0;
        end
      end
      ARG_RAMP: begin
        if (stop_rise) begin
          state_next = ARG_STOP_RAMP;
        end else if (tick) begin
          lvl = toward(level_reg, target, step);
          rem_next = LW'(tot % STEPS_PER_TICK_DIV);
        end
      end
      ARG_STOP_RAMP: begin
        if (level_reg == ss_level) begin
          state_next = ARG_STOP_HOLD;
          tick_cnt_next = '0;
        end else if (tick) begin
          lvl = toward(level_reg, ss_level, step);
          rem_next = LW'(tot % STEPS_PER_TICK_DIV);
        end
      end
      ARG_STOP_HOLD: begin
        lvl = ss_level;
        if (tick) begin
          state_next = ARG_LOCKED;
          lvl = offset_reg;
        end
      end
      ARG_LOCKED: begin
        lvl = offset_reg;
        if (!en_s && !stop_s) begin
          state_next = ARG_IDLE;
        end
      end
      default: begin
        state_next = ARG_IDLE;
        lvl = offset_reg;
      end
    endcase
    // enable fall overrides all, a pending stop keeps the lock
    if (en_fall) begin
      lvl = offset_reg;
      if (state_reg == ARG_STOP_RAMP || state_reg == ARG_STOP_HOLD ||
          state_reg == ARG_LOCKED || stop_s) begin
        state_next = ARG_LOCKED;
      end else begin
        state_next = ARG_IDLE;
      end
    end
    // ceiling wins even over the start/stop level
    level_next = (lvl > ceiling_reg) ? ceiling_reg : lvl;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ARG_IDLE;
      level_reg <= RST_OFFSET;
      tick_cnt_reg <= '0;
      rem_reg <= '0;
    end else begin
      state_reg <= state_next;
      level_reg <= level_next;
      tick_cnt_reg <= tick_cnt_next;
      rem_reg <= rem_next;
    end
  end

  // scaled output; gain in hundredths, zero gain saturates
  logic signed [LW:0] diff;
  logic [LW+7:0] num;
  logic [LW+7:0] quo;
  logic [OW-1:0] scaled_next;
  logic [OW-1:0] scaled_reg;
  assign diff = {level_reg[LW-1], level_reg} - {offset_reg[LW-1], offset_reg};

  always_comb begin
    num = (LW+8)'(diff[LW-1:0]) * (LW+8)'(GAIN_SCALE);
    quo = '0;
    if (diff <= 0) begin
      scaled_next = '0;
    end else if (gain_reg == 0) begin
      scaled_next = OUT_MAX;
    end else begin
      quo = num / (LW+8)'(gain_reg[LW-1:0]);
      scaled_next = (quo > (LW+8)'(OUT_MAX)) ? OUT_MAX : quo[OW-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      scaled_reg <= '0;
    end else begin
      scaled_reg <= scaled_next;
    end
  end

  assign scaled_analog_out = scaled_reg;
  assign current_level = level_reg;

  // read data one cycle after the strobe, zero otherwise
  logic [DW-1:0] rdata_next;
  logic [DW-1:0] rdata_reg;
  always_comb begin
    rdata_next = '0;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_LEVEL1: rdata_next = level1_reg[DW-1:0];
        ADDR_LEVEL2: rdata_next = level2_reg[DW-1:0];
        ADDR_CEILING: rdata_next = ceiling_reg[DW-1:0];
        ADDR_SS_OFF: rdata_next = ss_reg[DW-1:0];
        ADDR_RATE: rdata_next = rate_reg[DW-1:0];
        ADDR_GAIN: rdata_next = gain_reg[DW-1:0];
        ADDR_OFFSET: rdata_next = offset_reg[DW-1:0];
        ADDR_DECIMALS: rdata_next = dec_reg[DW-1:0];
        ADDR_CUR_LEVEL: rdata_next = level_reg[DW-1:0];
        ADDR_SCALED: rdata_next = {1'b0, scaled_reg};
        ADDR_STATE: rdata_next = {13'h0000, state_reg};
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
endmodule

//--- verilog/arg_pkg.sv
package arg_pkg;
  // value and bus widths
  localparam int LW = 18;
  localparam int DW = 16;
  localparam int AW = 4;
  localparam int OW = 15;

  // register offsets, one word each
  localparam logic [AW-1:0] ADDR_LEVEL1 = 4'h0;
  localparam logic [AW-1:0] ADDR_LEVEL2 = 4'h1;
  localparam logic [AW-1:0] ADDR_CEILING = 4'h2;
  localparam logic [AW-1:0] ADDR_SS_OFF = 4'h3;
  localparam logic [AW-1:0] ADDR_RATE = 4'h4;
  localparam logic [AW-1:0] ADDR_GAIN = 4'h5;
  localparam logic [AW-1:0] ADDR_OFFSET = 4'h6;
  localparam logic [AW-1:0] ADDR_DECIMALS = 4'h7;
  localparam logic [AW-1:0] ADDR_CUR_LEVEL = 4'h8;
  localparam logic [AW-1:0] ADDR_SCALED = 4'h9;
  localparam logic [AW-1:0] ADDR_STATE = 4'ha;

  // parameter ranges
  localparam logic signed [LW-1:0] LEVEL_MIN = -18'sd10000;
  localparam logic signed [LW-1:0] LEVEL_MAX = 18'sd20000;
  localparam logic signed [LW-1:0] SS_MIN = 18'sd0;
  localparam logic signed [LW-1:0] SS_MAX = 18'sd20000;
  localparam logic signed [LW-1:0] RATE_MIN = 18'sd1;
  localparam logic signed [LW-1:0] RATE_MAX = 18'sd10000;
  localparam logic signed [LW-1:0] GAIN_MIN = 18'sd0;
  localparam logic signed [LW-1:0] GAIN_MAX = 18'sd1000;
  localparam logic signed [LW-1:0] OFFS_MIN = -18'sd10000;
  localparam logic signed [LW-1:0] OFFS_MAX = 18'sd10000;
  localparam logic signed [LW-1:0] DEC_MIN = 18'sd0;
  localparam logic signed [LW-1:0] DEC_MAX = 18'sd3;

  // reset values
  localparam logic signed [LW-1:0] RST_LEVEL = 18'sd0;
  localparam logic signed [LW-1:0] RST_CEILING = 18'sd20000;
  localparam logic signed [LW-1:0] RST_SS = 18'sd0;
  localparam logic signed [LW-1:0] RST_RATE = 18'sd1;
  localparam logic signed [LW-1:0] RST_GAIN = 18'sd100;
  localparam logic signed [LW-1:0] RST_OFFSET = 18'sd0;
  localparam logic signed [LW-1:0] RST_DEC = 18'sd0;

  // arithmetic constants
  localparam logic [LW-1:0] STEPS_PER_TICK_DIV = 18'd10;
  localparam logic [OW-1:0] OUT_MAX = 15'h7fff;
  localparam logic [7:0] GAIN_SCALE = 8'd100;

  // timing
  localparam int CLK_MHZ = 125;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
  localparam int TW = 24;

  // ramp sequencer states, gray along the usual path from idle up to locked
  typedef enum logic [2:0] {
    ARG_IDLE = 3'h0,
    ARG_START_HOLD = 3'h1,
    ARG_RAMP = 3'h3,
    ARG_STOP_RAMP = 3'h2,
    ARG_STOP_HOLD = 3'h6,
    ARG_LOCKED = 3'h7
  } arg_state_e;
endpackage

//--- sim/arg_ramp_chk.sv
`timescale 1ns/100ps
module arg_ramp_chk #(
  parameter int TICK_LEN = arg_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control inputs
  input wire logic enable,
  input wire logic level_choice,
  input wire logic ramp_down_cmd,
  // register port
  input wire logic [arg_pkg::AW-1:0] reg_addr,
  input wire logic [arg_pkg::DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [arg_pkg::DW-1:0] reg_rdata,
  // results
  input wire logic signed [arg_pkg::LW-1:0] current_level,
  input wire logic [arg_pkg::OW-1:0] scaled_analog_out
);
  import arg_pkg::*;
  logic signed [LW-1:0] ceil_m;
  logic signed [LW-1:0] wr_ext;
  logic [15:0] lvl_lo;
  logic [15:0] out_ext;
  logic signed [LW-1:0] prev_reg;
  int since_reg;
  int since_next;
  assign lvl_lo = current_level[15:0];
  assign out_ext = {1'b0, scaled_analog_out};
  assign wr_ext = {{(LW-DW){reg_wdata[DW-1]}}, reg_wdata};
  // ceiling as software set it, clamped to the legal level range
  always_ff @(posedge clk) begin
    if (rst) begin
      ceil_m <= RST_CEILING;
    end else if (reg_wr && reg_addr == ADDR_CEILING) begin
      ceil_m <= (wr_ext > LEVEL_MAX) ? LEVEL_MAX :
        ((wr_ext < LEVEL_MIN) ? LEVEL_MIN : wr_ext);
    end
  end
  // cycles since the level last moved, saturating so it cannot wrap
  always_comb begin
    since_next = (since_reg < TICK_LEN) ? since_reg + 1 : since_reg;
    if (current_level != prev_reg) since_next = 0;
  end
  always_ff @(posedge clk) begin
    prev_reg <= current_level;
    since_reg <= rst ? 0 : since_next;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_rdata_one_slot: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its slot");
  a_read_level: assert property (
    reg_rd && reg_addr == ADDR_CUR_LEVEL |=> reg_rdata == $past(lvl_lo))
    else $error("level read wrong");
  a_read_scaled: assert property (
    reg_rd && reg_addr == ADDR_SCALED |=> reg_rdata == $past(out_ext))
    else $error("scaled read wrong");
  a_read_unmapped: assert property (
    reg_rd && reg_addr > ADDR_STATE |=> reg_rdata == '0)
    else $error("unmapped read not zero");
  // a new ceiling bounds the level from the edge after its write
  a_level_ceiling: assert property (current_level <= $past(ceil_m))
    else $error("level above ceiling");
  a_fall_zero: assert property (
    $fell(enable) |-> ##5 scaled_analog_out == '0)
    else $error("output not zero after enable fall");
  a_low_still: assert property (
    (!enable && !reg_wr) [*6] |=> $stable(current_level))
    else $error("level moved while disabled");
  a_tick_spacing: assert property (
    enable && $past(enable, 4) && current_level != prev_reg
      |-> since_reg >= TICK_LEN - 1)
    else $error("level updated faster than one tick");
  c_enable_rise: cover property ($rose(enable));
  c_stop: cover property ($rose(ramp_down_cmd));
  c_choice: cover property ($changed(level_choice));
endmodule

//--- sim/tb_arg_ramp.sv
`timescale 1ns/100ps
module tb_arg_ramp;
  import arg_pkg::*;
  localparam int TL = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic enable = 1'b0;
  logic level_choice = 1'b0;
  logic ramp_down_cmd = 1'b0;
  logic [AW-1:0] reg_addr = '0;
  logic [DW-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DW-1:0] reg_rdata;
  logic signed [LW-1:0] current_level;
  logic [OW-1:0] scaled_analog_out;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;

  arg_ramp #(.TICK_LEN(TL)) i_arg_ramp (.clk(clk), .rst(rst),
    .enable(enable), .level_choice(level_choice),
    .ramp_down_cmd(ramp_down_cmd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .current_level(current_level),
    .scaled_analog_out(scaled_analog_out));

  always #4 clk = ~clk;

  task automatic conclude();
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic check(input string what, input logic [LW-1:0] seen,
      input logic [LW-1:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check("read", {2'b0, reg_rdata}, {2'b0, e});
  endtask

  task automatic wlvl(input logic signed [LW-1:0] v);
    for (int i = 0; i < 200 && current_level !== v; i++) @(posedge clk) #1;
    check("level", current_level, v);
  endtask

  task automatic t_regs();
    logic [DW-1:0] rv [8] = '{16'h0, 16'h0, 16'h4e20, 16'h0, 16'h1,
      16'h64, 16'h0, 16'h0};
    for (int i = 0; i < 8; i++) rchk(AW'(i), rv[i]);
  endtask

  // out-of-range writes are clamped to the field range
  task automatic t_clamp();
    logic [AW-1:0] a [9] = '{ADDR_LEVEL1, ADDR_LEVEL2, ADDR_SS_OFF,
      ADDR_RATE, ADDR_RATE, ADDR_GAIN, ADDR_OFFSET, ADDR_DECIMALS,
      ADDR_DECIMALS};
    logic [DW-1:0] w [9] = '{16'h61a8, 16'hd120, 16'hfffb, 16'h0,
      16'h4e84, 16'h7d0, 16'h3a98, 16'h5, 16'h2};
    logic [DW-1:0] e [9] = '{16'h4e20, 16'hd8f0, 16'h0, 16'h1, 16'h2710,
      16'h3e8, 16'h2710, 16'h3, 16'h2};
    wr(ADDR_CUR_LEVEL, 16'h1234);
    rchk(ADDR_CUR_LEVEL, 16'h0);
    rchk(4'hf, 16'h0);
    for (int i = 0; i < 9; i++) begin
      wr(a[i], w[i]);
      rchk(a[i], e[i]);
    end
  endtask

  task automatic t_ramp();
    wr(ADDR_OFFSET, 16'h64);
    wr(ADDR_SS_OFF, 16'h32);
    wr(ADDR_LEVEL1, 16'h190);
    wr(ADDR_LEVEL2, 16'hc8);
    wr(ADDR_RATE, 16'h3e8);
    wr(ADDR_GAIN, 16'hc8);
    @(posedge clk) enable <= 1'b1;
    wlvl(150);
    rchk(ADDR_STATE, 16'h1);
    check("scaled", LW'(scaled_analog_out), 18'd25);
    wlvl(250);
    wlvl(350);
    wlvl(400);
    repeat (3 * TL) @(posedge clk);
    check("hold", current_level, 18'd400);
    rchk(ADDR_SCALED, 16'h96);
    @(posedge clk) level_choice <= 1'b1;
    wlvl(300);
    wlvl(200);
    @(posedge clk) ramp_down_cmd <= 1'b1;
    wlvl(150);
    rchk(ADDR_STATE, 16'h6);
    wlvl(100);
    rchk(ADDR_SCALED, 16'h0);
    @(posedge clk) enable <= 1'b0;
    repeat (8) @(posedge clk);
    enable <= 1'b1;
    repeat (3 * TL) @(posedge clk);
    check("locked", current_level, 18'd100);
    rchk(ADDR_STATE, 16'h7);
    @(posedge clk) enable <= 1'b0;
    ramp_down_cmd <= 1'b0;
    repeat (6) @(posedge clk);
    rchk(ADDR_STATE, 16'h0);
    @(posedge clk) enable <= 1'b1;
    wlvl(150);
    @(posedge clk) enable <= 1'b0;
    wlvl(100);
  endtask

  task automatic t_ceiling();
    @(posedge clk) level_choice <= 1'b0;
    wr(ADDR_CEILING, 16'h12c);
    @(posedge clk) enable <= 1'b1;
    wlvl(250);
    wlvl(300);
    repeat (3 * TL) @(posedge clk);
    check("ceiling", current_level, 18'd300);
    wr(ADDR_GAIN, 16'h0);
    rchk(ADDR_SCALED, 16'h7fff);
    @(posedge clk) enable <= 1'b0;
    // rate 15 gives steps of one then two, remainder cleared at start
    wr(ADDR_RATE, 16'hf);
    @(posedge clk) enable <= 1'b1;
    wlvl(151);
    repeat (TL) @(posedge clk);
    #1 check("step", current_level, 18'd153);
    @(posedge clk) enable <= 1'b0;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_clamp();
    t_ramp();
    t_ceiling();
    conclude();
  end
endmodule

bind arg_ramp arg_ramp_chk #(.TICK_LEN(TICK_LEN)) i_arg_ramp_chk (
  .clk(clk), .rst(rst), .enable(enable), .level_choice(level_choice),
  .ramp_down_cmd(ramp_down_cmd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .current_level(current_level),
  .scaled_analog_out(scaled_analog_out));
